// ===== hoist_load_cfg.svh
// Numeric constants of the hoist load processing chain.
// Assumes inclusion by its bare name from the package and the design file.
`ifndef HOIST_LOAD_CFG_SVH
`define HOIST_LOAD_CFG_SVH
// ==================================================
// Widths and divider last step index
`define SAMPLE_W      12
`define WEIGHT_W      16
`define WORD_W        32
`define DIV_STEPS     5'h1f
// ==================================================
// Limits and scales
`define WEIGHT_MAX    32'sh0000_7fff
`define SPEED_MAX     16'h7fff
`define LIVEZERO_MIN  12'sh199
`define GRAVITY_MMS2  32'h0000_2652
`define ACC_MAX       32'h0000_1329
`define ACC_NUM_MUL   32'h0000_0005
`define ACC_DEN_MUL   32'h0000_0003
`define FRAC_SHIFT    8
`define PCT_SCALE     32'h0000_0064
`define DISP_PCT_MAX  16'h00c8
`endif

// ===== hoist_load_pkg.sv
// Types shared by the hoist load processing chain.
// Assumes the constants header sits in the same folder.
`include "hoist_load_cfg.svh"
package hoist_load_pkg;
   // Sequencer states, idle plus one per division
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ACC  = 3'b001,
      ST_LIN  = 3'b010,
      ST_INR  = 3'b011,
      ST_PCT  = 3'b100
   } proc_state_t;
   // Two-point calibration settings
   typedef struct packed {
      logic [15:0] lowWeight;
      logic [15:0] highWeight;
      logic        lowTrig;
      logic        highTrig;
   } cal_cfg_t;
   // Ramp settings; ramp times in tenths of a second
   typedef struct packed {
      logic [15:0] nomSpeed;
      logic [15:0] accelRampTime;
      logic [15:0] decelRampTime;
      logic [7:0]  fastLowerFactor;
   } ramp_cfg_t;
   // Present motion state
   typedef struct packed {
      logic up;
      logic down;
      logic accelerating;
      logic decelerating;
   } motion_t;
   // Results towards protection functions and display
   typedef struct packed {
      logic [15:0] weight;
      logic [15:0] percent;
      logic [15:0] displayPercent;
      logic        valid;
   } load_out_t;
endpackage

// ===== hoist_load_signal_processing.sv
// Hoist load signal chain: calibration, torque estimate, inertia, percent.
// Assumes samples come from converter logic on clk, one strobe per sample.
//
// What this block does
// - Input is 11 magnitude bits plus sign
// - Live-zero loss raises alarm, motion continues
// - Low trigger rise captures low raw level
// - High trigger rise captures high raw level
// - Weight from straight line through pairs
// - 32-bit arithmetic, 16-bit weight result
// - Inertia removed by g over g+a
// - Acceleration from speed and active ramp
// - Nominal speed in cm/min, capped
// - Percent is weight over nominal load
// - Display percent net of tare, 0..200
// - Torque mode: upward steady torque times factor
// - Torque mode holds value otherwise
// - One switch selects torque or load cell
// - Percent and weight outputs to consumers
// - Shared-motion operation disables processing
`include "hoist_load_cfg.svh"
module hoist_load_signal_processing (
   input  wire logic                             clk,
   input  wire logic                             sys_rst,
   input  wire logic                             sampleValid,
   input  wire logic signed [`SAMPLE_W-1:0]      loadSample,
   input  wire logic                             liveZeroEn,
   input  wire hoist_load_pkg::cal_cfg_t         calCfg,
   input  wire hoist_load_pkg::ramp_cfg_t        rampCfg,
   input  wire hoist_load_pkg::motion_t          motion,
   input  wire logic [`WEIGHT_W-1:0]             nomLoad,
   input  wire logic [`WEIGHT_W-1:0]             tarePercent,
   input  wire logic                             torqueMode,
   input  wire logic signed [`WEIGHT_W-1:0]      torqueUp,
   input  wire logic [`WEIGHT_W-1:0]             torqueFactor,
   input  wire logic                             sharedMotion,
   output hoist_load_pkg::load_out_t             loadOut,
   output logic                                  liveZeroAlarm
);
   // ==================================================
   // Helpers
   // Magnitude of a signed word
   function automatic logic [31:0] absVal(input logic signed [31:0] v);
      absVal = v[31] ? 32'(-v) : 32'(v);
   endfunction
   // Clamp a signed word into 0..weight maximum
   function automatic logic [15:0] sat16(input logic signed [31:0] v);
      if (v[31])
         sat16 = 16'h0000;
      else if (v > `WEIGHT_MAX)
         sat16 = 16'h7fff;
      else
         sat16 = v[15:0];
   endfunction

   // ==================================================
   // Sample capture and live-zero supervision
   logic signed [11:0] sample_reg;        // Latest converter sample
   logic               pending_reg;       // Sample waiting for the chain
   logic               alarm_reg;         // Live-zero alarm level
   wire                belowLiveZero = loadSample < `LIVEZERO_MIN;

   // Sample is already signed 12-bit, so no conversion is needed
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sample_reg <= 12'sh000;
      end else if (sampleValid) begin
         sample_reg <= loadSample;
      end
   end

   // Alarm only flags; nothing in this block stops on it
   always_ff @(posedge clk) begin
      if (sys_rst || !liveZeroEn) begin
         alarm_reg <= 1'b0;
      end else if (sampleValid) begin
         alarm_reg <= belowLiveZero;
      end
   end
   assign liveZeroAlarm = alarm_reg;

   // ==================================================
   // Calibration capture on trigger rising edges
   logic               lowTrigD_reg;      // Previous low trigger
   logic               highTrigD_reg;     // Previous high trigger
   logic signed [11:0] rawLow_reg;        // Raw level of low weight
   logic signed [11:0] rawHigh_reg;       // Raw level of high weight
   wire                lowRise  = calCfg.lowTrig & ~lowTrigD_reg;
   wire                highRise = calCfg.highTrig & ~highTrigD_reg;

   // A trigger held high stores once; software toggles it for a new point
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lowTrigD_reg  <= 1'b0;
         highTrigD_reg <= 1'b0;
         rawLow_reg    <= 12'sh000;
         rawHigh_reg   <= 12'sh000;
      end else begin
         lowTrigD_reg  <= calCfg.lowTrig;
         highTrigD_reg <= calCfg.highTrig;
         if (lowRise)
            rawLow_reg <= sample_reg;
         if (highRise)
            rawHigh_reg <= sample_reg;
      end
   end

   // ==================================================
   // Torque based estimate
   logic [15:0]        estimate_reg;      // Held torque estimate
   wire                torqueSteadyUp = torqueMode & motion.up & ~motion.down
                                        & ~motion.accelerating & ~motion.decelerating;
   wire signed [31:0]  torqueProd = 32'(torqueUp) * $signed({16'h0000, torqueFactor});
   wire signed [31:0]  torqueLoad = torqueProd >>> `FRAC_SHIFT;

   // Only steady hoisting gives a clean torque; otherwise keep the last value
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         estimate_reg <= 16'h0000;
      end else if (torqueSteadyUp) begin
         estimate_reg <= sat16(torqueLoad);
      end
   end

   // ==================================================
   // Shared sequential divider, 32 steps per quotient
   logic [32:0]        divRem_reg;        // Partial remainder
   logic [31:0]        divQuo_reg;        // Quotient being built
   logic [31:0]        divDen_reg;        // Held divisor
   logic [4:0]         divCnt_reg;        // Step counter
   logic               divBusy_reg;       // Division running
   logic               divDone_reg;       // Quotient ready pulse
   logic [31:0]        divNum;            // Selected dividend
   logic [31:0]        divDen;            // Selected divisor
   hoist_load_pkg::proc_state_t state_reg;
   wire                divState = state_reg != hoist_load_pkg::ST_IDLE;
   wire                divGo    = divState & ~divBusy_reg & ~divDone_reg & ~sharedMotion;
   wire [32:0]         remShift = {divRem_reg[31:0], divQuo_reg[31]};
   wire [32:0]         remSub   = remShift - {1'b0, divDen_reg};
   wire                remFits  = ~remSub[32];

   // One divider serves all stages; samples arrive far slower than a pass.
   // Shared motion clears it as well, so a pass started right after it ends
   // never picks up a quotient left over from the aborted one.
   always_ff @(posedge clk) begin
      if (sys_rst || sharedMotion) begin
         divRem_reg  <= 33'h0_0000_0000;
         divQuo_reg  <= 32'h0000_0000;
         divDen_reg  <= 32'h0000_0000;
         divCnt_reg  <= 5'h00;
         divBusy_reg <= 1'b0;
         divDone_reg <= 1'b0;
      end else if (divGo) begin
         divRem_reg  <= 33'h0_0000_0000;
         divQuo_reg  <= divNum;
         divDen_reg  <= divDen;
         divCnt_reg  <= 5'h00;
         divBusy_reg <= 1'b1;
         divDone_reg <= 1'b0;
      end else if (divBusy_reg) begin
         divRem_reg  <= remFits ? remSub : remShift;
         divQuo_reg  <= {divQuo_reg[30:0], remFits};
         divCnt_reg  <= divCnt_reg + 5'h01;
         divBusy_reg <= divCnt_reg != `DIV_STEPS;
         divDone_reg <= divCnt_reg == `DIV_STEPS;
      end else begin
         divDone_reg <= 1'b0;
      end
   end

   // ==================================================
   // Stage operands
   logic [31:0]        accMag_reg;        // Acceleration in mm/s^2
   logic [15:0]        linWeight_reg;     // Calibrated weight
   logic [15:0]        comp_reg;          // Inertia-compensated weight
   // Speed above the documented ceiling is clamped
   wire [15:0]         speedLim  = rampCfg.nomSpeed[15] ? `SPEED_MAX
                                                        : rampCfg.nomSpeed;
   wire                slowing   = motion.decelerating;
   wire [15:0]         rampSel   = slowing ? rampCfg.decelRampTime : rampCfg.accelRampTime;
   wire [31:0]         rampRed   = ({16'h0000, rampSel} * {24'h00_0000, rampCfg.fastLowerFactor})
                                   >> `FRAC_SHIFT;
   // Fast lowering shortens the decel ramp when slowing downward
   wire [31:0]         rampEff   = (slowing & motion.down) ? rampRed
                                                           : {16'h0000, rampSel};
   wire [31:0]         accNum    = {16'h0000, speedLim} * `ACC_NUM_MUL;
   wire [31:0]         accDen    = rampEff * `ACC_DEN_MUL;
   // Positive when the load feels heavier (up faster, down slower)
   wire                accPos    = (motion.up & motion.accelerating) |
                                   (motion.down & motion.decelerating);
   wire                accNeg    = (motion.up & motion.decelerating) |
                                   (motion.down & motion.accelerating);
   wire signed [31:0]  accSigned = accPos ? $signed(accMag_reg) :
                                   accNeg ? -$signed(accMag_reg) : 32'sh0000_0000;
   wire signed [31:0]  xDiff     = 32'(sample_reg) - 32'(rawLow_reg);
   wire signed [31:0]  rDiff     = 32'(rawHigh_reg) - 32'(rawLow_reg);
   wire signed [31:0]  wDiff     = $signed({16'h0000, calCfg.highWeight})
                                   - $signed({16'h0000, calCfg.lowWeight});
   wire signed [31:0]  linProd   = xDiff * wDiff;
   wire                linNeg    = linProd[31] ^ rDiff[31];
   wire signed [31:0]  linStep   = linNeg ? -$signed(divQuo_reg) : $signed(divQuo_reg);
   wire signed [31:0]  linRaw    = $signed({16'h0000, calCfg.lowWeight}) + linStep;
   // Single switch picks the load source
   wire [15:0]         weightSel = torqueMode ? estimate_reg : linWeight_reg;
   wire [31:0]         inrNum    = {16'h0000, weightSel} * `GRAVITY_MMS2;
   wire [31:0]         inrDen    = 32'(`GRAVITY_MMS2 + accSigned);
   wire [31:0]         pctNum    = {16'h0000, comp_reg} * `PCT_SCALE;

   // Dividend and divisor follow the stage
   assign divNum = (state_reg == hoist_load_pkg::ST_ACC) ? accNum :
                   (state_reg == hoist_load_pkg::ST_LIN) ? absVal(linProd) :
                   (state_reg == hoist_load_pkg::ST_INR) ? inrNum : pctNum;
   assign divDen = (state_reg == hoist_load_pkg::ST_ACC) ? accDen :
                   (state_reg == hoist_load_pkg::ST_LIN) ? absVal(rDiff) :
                   (state_reg == hoist_load_pkg::ST_INR) ? inrDen : {16'h0000, nomLoad};

   // ==================================================
   // Check helpers: what entered the inertia division
   logic [15:0]        inrIn_reg;         // Weight handed to the division
   logic               inrSteady_reg;     // No acceleration at that moment

   // Operands may move while the quotient is built, so keep a copy
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         inrIn_reg     <= 16'h0000;
         inrSteady_reg <= 1'b0;
      end else if (divGo && state_reg == hoist_load_pkg::ST_INR) begin
         inrIn_reg     <= weightSel;
         inrSteady_reg <= accSigned == 32'sh0000_0000;
      end
   end

   // ==================================================
   // Stage sequencer
   logic [15:0]        percent_reg;       // Load in percent
   logic [15:0]        display_reg;       // Net display percent
   logic [15:0]        weightOut_reg;     // Weight to twin functions
   logic               valid_reg;         // Result pulse
   wire                accZero   = accDen == 32'h0000_0000;
   wire [31:0]         accClamp  = (divQuo_reg > `ACC_MAX) ? `ACC_MAX : divQuo_reg;
   wire [15:0]         pctSat    = (|divQuo_reg[31:16]) ? 16'hffff : divQuo_reg[15:0];
   wire [15:0]         pctFinal  = (nomLoad == 16'h0000) ? 16'h0000 : pctSat;
   wire [16:0]         netPct    = {1'b0, pctFinal} - {1'b0, tarePercent};
   wire [15:0]         netClamp  = netPct[16] ? 16'h0000 :
                                   (netPct[15:0] > `DISP_PCT_MAX) ? `DISP_PCT_MAX
                                                                  : netPct[15:0];

   // Shared-motion drives park the chain and keep outputs quiet
   always_ff @(posedge clk) begin
      if (sys_rst || sharedMotion) begin
         state_reg     <= hoist_load_pkg::ST_IDLE;
         pending_reg   <= 1'b0;
         valid_reg     <= 1'b0;
         accMag_reg    <= 32'h0000_0000;
         linWeight_reg <= 16'h0000;
         comp_reg      <= 16'h0000;
         percent_reg   <= 16'h0000;
         display_reg   <= 16'h0000;
         weightOut_reg <= 16'h0000;
      end else begin
         valid_reg <= 1'b0;
         if (sampleValid)
            pending_reg <= 1'b1;
         unique case (state_reg)
            hoist_load_pkg::ST_IDLE: begin
               // A sample arriving mid-pass waits for the next pass
               if (pending_reg) begin
                  pending_reg <= sampleValid;
                  state_reg   <= hoist_load_pkg::ST_ACC;
               end
            end
            hoist_load_pkg::ST_ACC: begin
               if (divDone_reg) begin
                  accMag_reg <= accZero ? 32'h0000_0000 : accClamp;
                  state_reg  <= hoist_load_pkg::ST_LIN;
               end
            end
            hoist_load_pkg::ST_LIN: begin
               if (divDone_reg) begin
                  // Equal raw points give no slope; fall back to the low weight
                  linWeight_reg <= (rDiff == 32'sh0000_0000) ? calCfg.lowWeight
                                                             : sat16(linRaw);
                  state_reg     <= hoist_load_pkg::ST_INR;
               end
            end
            hoist_load_pkg::ST_INR: begin
               if (divDone_reg) begin
                  comp_reg  <= sat16($signed(divQuo_reg));
                  state_reg <= hoist_load_pkg::ST_PCT;
               end
            end
            hoist_load_pkg::ST_PCT: begin
               if (divDone_reg) begin
                  percent_reg   <= pctFinal;
                  display_reg   <= netClamp;
                  weightOut_reg <= comp_reg;
                  valid_reg     <= 1'b1;
                  state_reg     <= hoist_load_pkg::ST_IDLE;
               end
            end
            default: begin
               state_reg <= hoist_load_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ==================================================
   // Outputs to protection functions and display
   assign loadOut.weight         = weightOut_reg;
   assign loadOut.percent        = percent_reg;
   assign loadOut.displayPercent = display_reg;
   assign loadOut.valid          = valid_reg;

   // ==================================================
   // Checks
   AST_ALARM_SET: assert property (@(posedge clk) disable iff (sys_rst)
      liveZeroEn && sampleValid && belowLiveZero ##1 liveZeroEn |-> liveZeroAlarm)
      else $error("live-zero alarm not raised");
   AST_ALARM_OFF: assert property (@(posedge clk) disable iff (sys_rst)
      !liveZeroEn |=> !liveZeroAlarm)
      else $error("live-zero alarm standing while supervision is off");
   AST_CAL_LOW: assert property (@(posedge clk) disable iff (sys_rst)
      lowRise |=> rawLow_reg == $past(sample_reg))
      else $error("low calibration level not captured");
   AST_CAL_HIGH: assert property (@(posedge clk) disable iff (sys_rst)
      highRise |=> rawHigh_reg == $past(sample_reg))
      else $error("high calibration level not captured");
   // Start edge, then 32 step edges; the done flag rises on the last step edge
   AST_DIV_LEN: assert property (@(posedge clk) disable iff (sys_rst || sharedMotion)
      divGo |-> ##33 divDone_reg)
      else $error("divider did not finish in 32 steps");
   AST_WEIGHT_SAT: assert property (@(posedge clk) disable iff (sys_rst)
      loadOut.valid |-> !loadOut.weight[15] && !linWeight_reg[15])
      else $error("weight wrapped past its limit");
   AST_DISP_RANGE: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(loadOut.valid) |-> loadOut.displayPercent <= `DISP_PCT_MAX)
      else $error("display percent out of range");
   AST_SHARED_QUIET: assert property (@(posedge clk) disable iff (sys_rst)
      sharedMotion ##1 sharedMotion |-> !loadOut.valid && state_reg == hoist_load_pkg::ST_IDLE)
      else $error("processing active in shared motion");
   AST_TORQUE_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
      !torqueSteadyUp |=> $stable(estimate_reg))
      else $error("torque estimate changed outside steady hoisting");
   AST_TORQUE_LOAD: assert property (@(posedge clk) disable iff (sys_rst)
      torqueSteadyUp && !torqueLoad[31] && torqueLoad <= `WEIGHT_MAX
      |=> estimate_reg == $past(torqueLoad[15:0]))
      else $error("torque estimate not loaded in steady hoisting");
   AST_STEADY_PASS: assert property (@(posedge clk) disable iff (sys_rst || sharedMotion)
      state_reg == hoist_load_pkg::ST_INR && divDone_reg && inrSteady_reg
      && !inrIn_reg[15] |=> comp_reg == $past(inrIn_reg))
      else $error("steady speed changed the weight");
   AST_PCT_PAIR: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(loadOut.valid) && nomLoad == 16'h0000 |-> loadOut.percent == 16'h0000)
      else $error("percent without nominal load");
endmodule

// ===== load_cell_model.sv
// Behavioural load cell converter standing in front of the hoist load chain.
// Assumes one clock shared with the chain and requests from the bench.
module load_cell_model (
   input  wire logic               clk,
   input  wire logic               convReq,
   input  wire logic signed [31:0] level,
   output logic                    sampleValid,
   output logic signed [11:0]      loadSample
);
   timeunit 1ns;
   timeprecision 1ps;
   logic pendReg;   // Conversion waiting for the next falling edge

   // ==========================================
   // Request capture
   always @(posedge clk) begin
      pendReg <= convReq;
   end

   // ==========================================
   // Sample launch on the falling edge, then the line drifts
   // Inverting the stale code after the strobe keeps a design that samples
   // outside the strobe from matching by luck
   always @(negedge clk) begin
      if (pendReg) begin
         sampleValid <= 1'h1;
         loadSample  <= (level > 2047) ? 12'sh7ff :
                        (level < -2048) ? 12'sh800 : level[11:0];
      end else begin
         sampleValid <= 1'h0;
         if (sampleValid) loadSample <= ~loadSample;
      end
   end

   initial begin
      sampleValid = 1'h0;
      loadSample  = 12'sh000;
   end
endmodule

// ===== hoist_load_signal_processing_tb.sv
// Self-checking bench for the hoist load chain: calibration, inertia, torque.
// Assumes the package and the converter model are compiled beforehand.
module hoist_load_signal_processing_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // Calibration points used by the linW expectations
   localparam int CAL_LR = 100;
   localparam int CAL_HR = 1100;
   localparam int CAL_LW = 1000;
   localparam int CAL_HW = 30000;
   logic                      clk = 1'h0;
   logic                      sys_rst = 1'h1;
   logic                      liveZeroEn = 1'h0;
   logic                      torqueMode = 1'h0;
   logic                      sharedMotion = 1'h0;
   logic                      convReq = 1'h0;
   logic signed [31:0]        level = 32'sh0;
   logic                      sampleValid;
   logic signed [11:0]        loadSample;
   hoist_load_pkg::cal_cfg_t  calCfg = '0;
   hoist_load_pkg::ramp_cfg_t rampCfg = '0;
   hoist_load_pkg::motion_t   motion = '0;
   logic [15:0]               nomLoad = 16'h0;
   logic [15:0]               tarePercent = 16'h0;
   logic [15:0]               torqueFactor = 16'h0;
   logic signed [15:0]        torqueUp = 16'sh0;
   hoist_load_pkg::load_out_t loadOut;
   logic                      liveZeroAlarm;
   int                        fail_count = 0;
   int                        compares = 0;
   int                        cyc;
   // Scenario tables: samples, loads, tares, motions and expected acceleration
   int xs[4] = '{600, 2047, -500, 101};
   int nl[4] = '{31000, 10000, 31000, 0};
   int tp[4] = '{10, 0, 10, 10};
   logic [3:0] mv[5] = '{4'ha, 4'h9, 4'h6, 4'h5, 4'ha};
   int ar[5] = '{10, 10, 10, 10, 100};
   // 6000*5/(3*10)=1000, decel ramp 20 gives 500, halved ramp downwards, cap 32767
   int ae[5] = '{1000, -500, -1000, 1000, 546};

   always #2 clk = ~clk;

   load_cell_model u_load_cell_model (
      .clk(clk), .convReq(convReq), .level(level),
      .sampleValid(sampleValid), .loadSample(loadSample));

   hoist_load_signal_processing u_hoist_load_signal_processing (
      .clk(clk), .sys_rst(sys_rst), .sampleValid(sampleValid), .loadSample(loadSample),
      .liveZeroEn(liveZeroEn), .calCfg(calCfg), .rampCfg(rampCfg), .motion(motion),
      .nomLoad(nomLoad), .tarePercent(tarePercent), .torqueMode(torqueMode),
      .torqueUp(torqueUp), .torqueFactor(torqueFactor), .sharedMotion(sharedMotion),
      .loadOut(loadOut), .liveZeroAlarm(liveZeroAlarm));

   // ==========================================
   // Comparison and verdict
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   task automatic stop_test();
      $display("Compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // ==========================================
   // Access: one conversion, then a bounded wait for the result strobe
   task automatic runPass(input int x, output int n);
      @(negedge clk);
      level   = x;
      convReq = 1'h1;
      @(negedge clk);
      convReq = 1'h0;
      n = 0;
      while (loadOut.valid !== 1'h1 && n < 300) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask

   // Straight line through the two stored points, clipped to the weight range
   function automatic int linW(input int x);
      int w;
      w = CAL_LW + (x - CAL_LR) * (CAL_HW - CAL_LW) / (CAL_HR - CAL_LR);
      return (w < 0) ? 0 : (w > 32767) ? 32767 : w;
   endfunction

   // Expected chain outputs from an uncompensated weight and acceleration
   task automatic expectPass(input int x, input int w0, input int a);
      int n, w, p, d;
      runPass(x, n);
      w = w0 * 9810 / (9810 + a);
      w = (w > 32767) ? 32767 : w;
      p = (nomLoad == 16'h0) ? 0 : w * 100 / int'(nomLoad);
      p = (p > 65535) ? 65535 : p;
      d = p - int'(tarePercent);
      d = (d < 0) ? 0 : (d > 200) ? 200 : d;
      check("valid", 1, loadOut.valid);
      check("weight", w, loadOut.weight);
      check("percent", p, loadOut.percent);
      check("displayPercent", d, loadOut.displayPercent);
   endtask

   // ==========================================
   // Main sequence
   initial begin
      repeat (2) @(posedge clk);
      @(negedge clk);
      sys_rst = 1'h0;
      @(posedge clk);
      #1;
      check("reset weight", 0, loadOut.weight);
      check("reset valid", 0, loadOut.valid);
      // Live-zero supervision: below and at the threshold, then below again
      @(negedge clk);
      liveZeroEn = 1'h1;
      runPass(256, cyc);
      check("alarm low", 1, liveZeroAlarm);
      check("pass despite alarm", 1, loadOut.valid);
      runPass(409, cyc);
      check("alarm at threshold", 0, liveZeroAlarm);
      runPass(256, cyc);
      check("alarm raised again", 1, liveZeroAlarm);
      @(negedge clk);
      liveZeroEn = 1'h0;
      @(posedge clk);
      #1;
      check("alarm disabled", 0, liveZeroAlarm);
      // Two-point calibration, weights set before each trigger rise
      @(negedge clk);
      calCfg.lowWeight  = 16'h03e8;
      calCfg.highWeight = 16'h7530;
      runPass(CAL_LR, cyc);
      @(negedge clk);
      calCfg.lowTrig = 1'h1;
      runPass(CAL_HR, cyc);
      @(negedge clk);
      calCfg.highTrig = 1'h1;
      motion = 4'h8;
      rampCfg = '{16'h1770, 16'h000a, 16'h0014, 8'h80};
      // Held triggers must not recapture later samples
      for (int i = 0; i < 4; i++) begin
         @(negedge clk);
         nomLoad = nl[i][15:0];
         tarePercent = tp[i][15:0];
         expectPass(xs[i], linW(xs[i]), 0);
      end
      // Inertia in every direction and ramp, last one with an oversize speed
      for (int i = 0; i < 5; i++) begin
         @(negedge clk);
         motion = mv[i];
         nomLoad = 16'h7918;
         tarePercent = 16'h0;
         rampCfg.accelRampTime = ar[i][15:0];
         if (i == 4) rampCfg.nomSpeed = 16'hffff;
         expectPass(600, linW(600), ae[i]);
      end
      // Torque estimate: steady up loads, anything else holds
      @(negedge clk);
      motion = 4'h8;
      torqueMode = 1'h1;
      torqueUp = 16'sh03e8;
      torqueFactor = 16'h0200;
      expectPass(600, 2000, 0);
      @(negedge clk);
      motion = 4'h4;
      torqueUp = 16'sh0bb8;
      expectPass(600, 2000, 0);
      @(negedge clk);
      motion = 4'ha;
      rampCfg = '{16'h1770, 16'h000a, 16'h0014, 8'h80};
      expectPass(600, 2000, 1000);
      @(negedge clk);
      motion = 4'h8;
      torqueMode = 1'h0;
      expectPass(600, linW(600), 0);
      // Shared motion: no results, outputs forced low, calibration kept
      @(negedge clk);
      sharedMotion = 1'h1;
      runPass(600, cyc);
      check("shared valid", 0, loadOut.valid);
      check("shared weight", 0, loadOut.weight);
      @(negedge clk);
      sharedMotion = 1'h0;
      expectPass(600, linW(600), 0);
      stop_test();
   end

   // ==========================================
   // Watchdog: about twenty passes of some 140 cycles fit well inside this span
   initial begin
      #80000;
      fail_count++;
      $display("Error watchdog expected 0 seen 1");
      stop_test();
   end
endmodule
